// ===== rtl/psq_top.sv
// Bus initialise and power-fail sequencer: watches the power-status lines,
// drives the init pulse, raises power-fail interrupt, latches boot strap.
// Assumes a 100 MHz ref_clk; bus lines are asynchronous, active low, open drain.
// Function
// - Low-active lines asserted when low
// - Ignore bus while dc-power-low asserted
// - Ac-power-low assertion raises power-fail interrupt
// - Power-status lines are wired-OR
// - Init at start, software reset, adapter reset
// - Initialise only after dc-power-low deasserts
// - Power-up init pulse 10 us to 120 ms
// - Run only after ac-power-low deasserts
// - Halt activity while dc-power-low asserted
// - Brief init pulse when dc asserts
// - Ac-power-low may cut init, minimum 1 us
`timescale 1ns/1ns
`default_nettype none
module psq_top
   import psq_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic dc_power_low_n,       // Wired-OR bus line, low = asserted
   input  wire logic ac_power_low_n,       // Wired-OR bus line, low = asserted
   input  wire logic boot_strap_latch_in_n, // Strap, low = boot enabled
   input  wire logic sw_reset,             // Software reset instruction pulse
   input  wire logic adapter_reset,        // Explicit adapter reset command pulse
   output logic      bus_init_n,           // Bus-initialize, low = asserted
   output logic      bus_init_oe_n,        // Low while driving bus-initialize
   output logic      power_fail_irq,       // One-cycle power-fail interrupt
   output logic      halt,                 // High while activity is halted
   output logic      run,                  // High in normal operation
   output logic      boot_enable           // Strap captured at dc release
);
   typedef struct packed {
      psq_state_t state;
      logic       init;
      logic       irq;
      logic       halt;
      logic       run;
      logic       boot;
      logic       ac_prev;
      logic       strap_meta;
      logic       strap_sync;
   } psq_st_t;

   psq_st_t              st;
   psq_st_t              next_st;
   logic                 tmr_load;
   logic [CNT_W-1:0]     tmr_val;
   logic                 tmr_done;
   logic [CNT_W-1:0]     tmr_elapsed;

   psq_sync_if sync_if ();

   // Synchronise both power-status lines
   psq_sync psq_sync_inst (
      .ref_clk        (ref_clk),
      .rstn           (rstn),
      .dc_power_low_n (dc_power_low_n),
      .ac_power_low_n (ac_power_low_n),
      .sync           (sync_if.src)
   );

   // Pulse timer
   psq_timer psq_timer_inst (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done),
      .elapsed  (tmr_elapsed)
   );

   // Sequencer next-state logic
   always_comb begin
      next_st            = st;
      tmr_load           = 1'b0;
      tmr_val            = CNT_W'(INIT_PULSE_CYC);
      next_st.irq        = 1'b0;
      next_st.ac_prev    = sync_if.ac_low;
      next_st.strap_meta = ~boot_strap_latch_in_n;
      next_st.strap_sync = st.strap_meta;
      // Ac-power-low rising edge in any powered state raises the interrupt
      if (st.state != PSQ_OFF && sync_if.ac_low && !st.ac_prev) begin
         next_st.irq = 1'b1;
      end
      case (st.state)
         PSQ_OFF: begin
            next_st.halt = 1'b1;
            next_st.run  = 1'b0;
            next_st.init = 1'b0;
            // Everything but dc-power-low is ignored here
            if (!sync_if.dc_low) begin
               next_st.boot  = st.strap_sync;
               next_st.init  = 1'b1;
               next_st.state = PSQ_INIT;
               tmr_load      = 1'b1;
            end
         end
         PSQ_INIT: begin
            if (sync_if.dc_low) begin
               next_st.state = PSQ_DOWN;
               next_st.init  = 1'b1;
               tmr_load      = 1'b1;
               tmr_val       = CNT_W'(DOWN_PULSE_CYC);
            end else if (tmr_done
                         || (sync_if.ac_low && tmr_elapsed >= CNT_W'(INIT_MIN_CYC - 1))) begin
               next_st.init  = 1'b0;
               next_st.state = PSQ_WAIT_AC;
            end
         end
         PSQ_WAIT_AC: begin
            if (sync_if.dc_low) begin
               next_st.state = PSQ_DOWN;
               next_st.init  = 1'b1;
               next_st.halt  = 1'b1;
               tmr_load      = 1'b1;
               tmr_val       = CNT_W'(DOWN_PULSE_CYC);
            end else if (!sync_if.ac_low) begin
               next_st.halt  = 1'b0;
               next_st.run   = 1'b1;
               next_st.state = PSQ_RUN;
            end
         end
         PSQ_RUN: begin
            if (sync_if.dc_low) begin
               next_st.state = PSQ_DOWN;
               next_st.init  = 1'b1;
               next_st.halt  = 1'b1;
               next_st.run   = 1'b0;
               tmr_load      = 1'b1;
               tmr_val       = CNT_W'(DOWN_PULSE_CYC);
            end else if (sw_reset || adapter_reset) begin
               next_st.init  = 1'b1;
               next_st.halt  = 1'b1;
               next_st.run   = 1'b0;
               next_st.state = PSQ_INIT;
               tmr_load      = 1'b1;
            end
         end
         PSQ_DOWN: begin
            next_st.halt = 1'b1;
            next_st.run  = 1'b0;
            if (tmr_done) begin
               next_st.init  = 1'b0;
               next_st.state = PSQ_OFF;
            end
         end
         default: begin
            next_st.state = PSQ_OFF;
         end
      endcase
   end

   // State register; come up halted as if dc-power-low were asserted
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '{state: PSQ_OFF, init: 1'b0, irq: 1'b0, halt: 1'b1, run: 1'b0,
                 boot: 1'b0, ac_prev: 1'b1, strap_meta: 1'b0, strap_sync: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from flops
   assign bus_init_n     = ~st.init;
   assign bus_init_oe_n  = ~st.init;
   assign power_fail_irq = st.irq;
   assign halt           = st.halt;
   assign run            = st.run;
   assign boot_enable    = st.boot;
endmodule : psq_top
`default_nettype wire

// ===== rtl/psq_pkg.sv
// Package for the bus init and power-fail sequencer: timing constants and states.
// Assumes a 100 MHz reference clock.
package psq_pkg;
   localparam int unsigned CLK_MHZ          = 100;
   localparam int unsigned INIT_PULSE_US    = 10;    // Power-up init pulse length
   localparam int unsigned INIT_MIN_NS      = 1000;  // Least init length when cut short
   localparam int unsigned DOWN_PULSE_US    = 1;     // Brief init pulse on power-down
   localparam int unsigned INIT_PULSE_CYC   = INIT_PULSE_US * CLK_MHZ;
   localparam int unsigned INIT_MIN_CYC     = (INIT_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DOWN_PULSE_CYC   = DOWN_PULSE_US * CLK_MHZ;
   localparam int unsigned CNT_W            = 12;
   localparam logic [1:0]  SYNC_RESET_VAL   = 2'h3;  // Lines read asserted under reset

   typedef enum logic [2:0] {
      PSQ_OFF,      // Dc-power-low asserted, everything halted
      PSQ_INIT,     // Init pulse at start, software or adapter reset
      PSQ_WAIT_AC,  // Waiting for ac-power-low to clear
      PSQ_RUN,      // Normal operation
      PSQ_DOWN      // Brief init pulse after dc-power-low assertion
   } psq_state_t;
endpackage : psq_pkg

// ===== rtl/psq_sync_if.sv
// Interface carrying synchronised power-status levels between the sync stage and the sequencer.
// Assumes one clock domain on both sides.
`timescale 1ns/1ns
`default_nettype none
interface psq_sync_if;
   logic dc_low;   // Dc-power-low asserted, active high after sync
   logic ac_low;   // Ac-power-low asserted, active high after sync
   modport src (output dc_low, output ac_low);
   modport dst (input dc_low, input ac_low);
endinterface : psq_sync_if
`default_nettype wire

// ===== rtl/psq_sync.sv
// Two-stage synchroniser for the active-low wired-OR power-status lines.
// Assumes the lines arrive asynchronously from the backplane.
`timescale 1ns/1ns
`default_nettype none
module psq_sync
   import psq_pkg::*;
(
   input  wire logic  ref_clk,
   input  wire logic  rstn,
   input  wire logic  dc_power_low_n,
   input  wire logic  ac_power_low_n,
   psq_sync_if.src    sync
);
   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] stable;
   } psq_sync_st_t;

   psq_sync_st_t st;
   psq_sync_st_t next_st;

   // Invert to active high and shift through two flops
   always_comb begin
      next_st        = st;
      next_st.meta   = {~dc_power_low_n, ~ac_power_low_n};
      next_st.stable = st.meta;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '{meta: SYNC_RESET_VAL, stable: SYNC_RESET_VAL};
      end else begin
         st <= next_st;
      end
   end

   // Only the second stage leaves this module
   assign sync.dc_low = st.stable[1];
   assign sync.ac_low = st.stable[0];
endmodule : psq_sync
`default_nettype wire

// ===== rtl/psq_timer.sv
// Down counter used to time init pulses.
// Assumes load and count come from the sequencer on the same clock.
`timescale 1ns/1ns
`default_nettype none
module psq_timer
   import psq_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] load_val,
   output logic                  done,
   output logic [CNT_W-1:0]      elapsed
);
   typedef struct packed {
      logic [CNT_W-1:0] left;
      logic [CNT_W-1:0] run;
   } psq_tmr_st_t;

   psq_tmr_st_t st;
   psq_tmr_st_t next_st;

   // Load restarts both the remaining and elapsed counts
   always_comb begin
      next_st = st;
      // The load edge is the first cycle of the pulse, so done follows load_val - 1 cycles later
      if (load) begin
         next_st.left = load_val - 1'b1;
         next_st.run  = '0;
      end else if (st.left != '0) begin
         next_st.left = st.left - 1'b1;
         next_st.run  = st.run + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done    = (st.left == '0);
   assign elapsed = st.run;
endmodule : psq_timer
`default_nettype wire

// ===== testbench/psq_supply_model.sv
// Model of the supplies and devices on the power-status lines.
// Assumes the bench sets which supply pulls each line low.
`timescale 1ns/1ns
`default_nettype none
module psq_supply_model (
   input  wire logic [1:0] dc_pull,
   input  wire logic [1:0] ac_pull,
   input  wire logic       bus_init_n,
   output wire logic       dc_power_low_n,
   output wire logic       ac_power_low_n,
   output int              n_inits
);
   // Open-drain lines with pull-up: low while any supply pulls
   assign dc_power_low_n = ~|dc_pull;
   assign ac_power_low_n = ~|ac_pull;
   // A device returns to its power-up state on each init pulse
   initial n_inits = 0;
   always @(negedge bus_init_n) n_inits++;
endmodule : psq_supply_model
`default_nettype wire

// ===== testbench/psq_top_sva.sv
// Port timing checker for the sequencer.
// Assumes it is bound onto psq_top.
`timescale 1ns/1ns
`default_nettype none
module psq_top_chk
   import psq_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic dc_power_low_n,
   input wire logic ac_power_low_n,
   input wire logic boot_strap_latch_in_n,
   input wire logic sw_reset,
   input wire logic adapter_reset,
   input wire logic bus_init_n,
   input wire logic bus_init_oe_n,
   input wire logic power_fail_irq,
   input wire logic halt,
   input wire logic run,
   input wire logic boot_enable
);
   int   cnt;
   logic cut;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // Length of the init pulse and whether a power line cut it short
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
         cut <= 1'b0;
      end else begin
         cnt <= bus_init_n ? 0 : cnt + 1;
         cut <= !bus_init_n && (cut || !ac_power_low_n || !dc_power_low_n);
      end
   end
   AST_START: assert property ($rose(dc_power_low_n) ##1 dc_power_low_n[*3] |-> !bus_init_n)
      else $error("no init after dc release");
   AST_FULL: assert property ($rose(bus_init_n) && !cut |-> cnt == INIT_PULSE_CYC)
      else $error("init pulse length");
   AST_MIN: assert property ($rose(bus_init_n) |-> cnt >= INIT_MIN_CYC)
      else $error("init pulse too short");
   AST_DOWN: assert property ($fell(dc_power_low_n) && run |-> ##[2:4] !bus_init_n)
      else $error("no init on dc assert");
   AST_HALT: assert property (!dc_power_low_n[*4] |=> halt && !run)
      else $error("not halted under dc");
   AST_IRQ: assert property ($fell(ac_power_low_n) && run |-> !power_fail_irq[*2] ##[1:2] power_fail_irq)
      else $error("irq timing");
   AST_IRQ_ONE: assert property (power_fail_irq |=> !power_fail_irq)
      else $error("irq too long");
   AST_RUN: assert property ($rose(run) |-> bus_init_n && $past(ac_power_low_n, 3))
      else $error("run with ac asserted");
   AST_SW: assert property ((sw_reset || adapter_reset) && run |-> ##[1:3] !bus_init_n)
      else $error("no init on reset");
   AST_BOOT: assert property (run && $past(run) |-> $stable(boot_enable))
      else $error("strap changed");
   AST_OE: assert property (bus_init_oe_n == bus_init_n)
      else $error("enable differs");
endmodule : psq_top_chk
bind psq_top psq_top_chk psq_top_chk_inst (.ref_clk, .rstn, .dc_power_low_n, .ac_power_low_n,
   .boot_strap_latch_in_n, .sw_reset, .adapter_reset, .bus_init_n, .bus_init_oe_n,
   .power_fail_irq, .halt, .run, .boot_enable);
`default_nettype wire

// ===== testbench/psq_top_test.sv
// Bench for the sequencer: power-up, ac fail, resets, cut pulse, power-down.
// Assumes the supply model drives the power-status lines.
`timescale 1ns/1ns
`default_nettype none
module psq_top_test
   import psq_pkg::*;
;
   logic       ref_clk = 1'b0;
   logic       rstn = 1'b0;
   logic [1:0] dc_pull = 2'h3;
   logic [1:0] ac_pull = 2'h3;
   logic       boot_strap_latch_in_n = 1'b0;
   logic       sw_reset = 1'b0;
   logic       adapter_reset = 1'b0;
   wire logic  dc_power_low_n, ac_power_low_n;
   logic       bus_init_n, bus_init_oe_n, power_fail_irq, halt, run, boot_enable;
   int         n_inits, len, mismatches = 0, n_compared = 0;
   always #5 ref_clk = ~ref_clk;
   psq_supply_model psq_supply_model_inst (.dc_pull, .ac_pull, .bus_init_n, .dc_power_low_n,
      .ac_power_low_n, .n_inits);
   psq_top psq_top_inst (.ref_clk, .rstn, .dc_power_low_n, .ac_power_low_n, .boot_strap_latch_in_n,
      .sw_reset, .adapter_reset, .bus_init_n, .bus_init_oe_n, .power_fail_irq, .halt, .run, .boot_enable);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask : check
   // Waits for the init pulse, then counts its low cycles
   task automatic pulse(output int n);
      n = 0;
      repeat (20) if (bus_init_n) @(negedge ref_clk);
      while (bus_init_n === 1'b0 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
   endtask : pulse
   task automatic t_powerup;
      @(negedge ref_clk) dc_pull = 2'h1;
      repeat (20) @(negedge ref_clk);
      check(bus_init_n, 1'b1);
      dc_pull = 2'h0;
      @(negedge ref_clk) boot_strap_latch_in_n = 1'b1;
      pulse(len);
      check(len >= INIT_MIN_CYC && len <= INIT_PULSE_CYC, 1'b1);
      check(boot_enable, 1'b1);
      repeat (10) @(negedge ref_clk);
      check({run, halt}, 2'h1);
      ac_pull = 2'h0;
      repeat (5) @(negedge ref_clk);
      check({run, halt}, 2'h2);
      $display("powerup done");
   endtask : t_powerup
   task automatic t_acfail;
      int k;
      k = 0;
      ac_pull = 2'h2;
      repeat (10) begin
         @(negedge ref_clk);
         k += power_fail_irq;
      end
      check(k, 1);
      ac_pull = 2'h0;
      repeat (5) @(negedge ref_clk);
      $display("ac fail done");
   endtask : t_acfail
   task automatic t_resets;
      for (int i = 0; i < 2; i++) begin
         {adapter_reset, sw_reset} = 2'h1 << i;
         @(negedge ref_clk) {adapter_reset, sw_reset} = 2'h0;
         pulse(len);
         check(len, INIT_PULSE_CYC);
         repeat (5) @(negedge ref_clk);
         check(run, 1'b1);
      end
      check(n_inits, 3);
      $display("resets done");
   endtask : t_resets
   task automatic t_cut;
      sw_reset = 1'b1;
      @(negedge ref_clk) sw_reset = 1'b0;
      repeat (300) @(negedge ref_clk);
      ac_pull = 2'h1;
      pulse(len);
      check(len + 300 < INIT_PULSE_CYC, 1'b1);
      ac_pull = 2'h0;
      repeat (5) @(negedge ref_clk);
      check(run, 1'b1);
      $display("cut done");
   endtask : t_cut
   task automatic t_down;
      dc_pull = 2'h2;
      pulse(len);
      check(len, DOWN_PULSE_CYC);
      repeat (5) @(negedge ref_clk);
      check({run, halt}, 2'h1);
      sw_reset = 1'b1;
      @(negedge ref_clk) sw_reset = 1'b0;
      repeat (20) @(negedge ref_clk);
      check(bus_init_n, 1'b1);
      $display("power-down done");
   endtask : t_down
   task automatic results;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results
   // Main sequence after reset
   initial begin
      repeat (12) @(negedge ref_clk);
      rstn = 1'b1;
      t_powerup;
      t_acfail;
      t_resets;
      t_cut;
      t_down;
      results;
   end
   // Watchdog well past the expected run
   initial begin
      #100000;
      mismatches++;
      results;
   end
endmodule : psq_top_test
`default_nettype wire
